// ### bench/rtc_bcd_time_alarm_regs_tb_top.sv
// self-checking bench for the value and alarm digit register file
// assumes the design carries its own inline assertions beside the model checks here
`timescale 1ns/1ps
module rtc_bcd_time_alarm_regs_tb_top;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic unlock = 1'b0;
	logic tLoad = 1'b0;
	logic aLoad = 1'b0;
	logic accEn = 1'b0;
	logic accWrite = 1'b0;
	logic [1:0] tVal = 2'h0;
	logic [1:0] aVal = 2'h0;
	logic [1:0] accSel = 2'h0;
	logic [7:0] accWdata = 8'h00;
	logic [7:0] readData;
	logic readValid;
	logic [1:0] tPtr;
	logic [1:0] aPtr;
	logic [7:0] model [16];
	int n_fail = 0;
	int comparisons = 0;
	rtc_bcd_time_alarm_regs i_dut (.mclk(mclk), .reset_n(reset_n), .value_write_unlock(unlock),
		.timePtrLoad(tLoad), .timePtrValue(tVal), .alarmPtrLoad(aLoad), .alarmPtrValue(aVal),
		.accEn(accEn), .accWrite(accWrite), .accSel(accSel), .accWdata(accWdata),
		.readData(readData), .readValid(readValid), .time_window_pointer(tPtr),
		.alarm_window_pointer(aPtr));
	always #2.5 mclk = ~mclk;
	// slot is {bank, pointer, high}
	function automatic logic [7:0] maskOf(input logic [3:0] slot);
		if (slot[3:1] == 3'h7) return 8'h00; // alarm pointer 3 has nothing behind it
		case (slot[2:0])
			3'h0, 3'h1: return 8'h7f;
			3'h2, 3'h4: return 8'h3f;
			3'h3: return 8'h07;
			3'h5: return 8'h1f;
			3'h6: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction : maskOf
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	// pointer loaded one cycle ahead so load never collides with decrement
	task automatic access(input logic [3:0] slot, input logic wr, input logic [7:0] data);
		logic [7:0] expRd;
		logic [1:0] expPtr;
		expRd = wr ? 8'h00 : model[slot];
		expPtr = (slot[0] && slot[2:1] != 2'h0) ? slot[2:1] - 2'h1 : slot[2:1];
		@(posedge mclk) #1;
		tLoad = !slot[3];
		aLoad = slot[3];
		tVal = slot[2:1];
		aVal = slot[2:1];
		@(posedge mclk) #1;
		tLoad = 1'b0;
		aLoad = 1'b0;
		accEn = 1'b1;
		accWrite = wr;
		accSel = {slot[3], slot[0]};
		accWdata = data;
		@(posedge mclk) #1;
		accEn = 1'b0;
		check("readData", readData, expRd);
		check("readValid", {7'h00, readValid}, {7'h00, !wr});
		check("pointer", {6'h00, slot[3] ? aPtr : tPtr}, {6'h00, expPtr});
		if (wr && unlock) model[slot] = data & maskOf(slot);
	endtask : access
	// back-to-back high reads from pointer 3 walk down and stop at zero
	task automatic burst(input logic bank);
		logic [1:0] p;
		@(posedge mclk) #1;
		tLoad = !bank;
		aLoad = bank;
		tVal = 2'h3;
		aVal = 2'h3;
		@(posedge mclk) #1;
		tLoad = 1'b0;
		aLoad = 1'b0;
		accEn = 1'b1;
		accWrite = 1'b0;
		accSel = {bank, 1'b1};
		for (int i = 3; i >= -1; i--) begin
			p = (i < 0) ? 2'h0 : 2'(i);
			@(posedge mclk) #1;
			check("burst read", readData, model[{bank, p, 1'b1}]);
		end
		accEn = 1'b0;
	endtask : burst
	// low write and read back to back, then a high read that meets a pointer load
	task automatic pair(input logic bank, input logic [1:0] ptr, input logic [7:0] data);
		logic [3:0] slot;
		slot = {bank, ptr, 1'b0};
		@(posedge mclk) #1;
		tLoad = !bank;
		aLoad = bank;
		tVal = ptr;
		aVal = ptr;
		@(posedge mclk) #1;
		tLoad = 1'b0;
		aLoad = 1'b0;
		accEn = 1'b1;
		accWrite = 1'b1;
		accSel = {bank, 1'b0};
		accWdata = data;
		@(posedge mclk) #1;
		if (unlock) model[slot] = data & maskOf(slot);
		accWrite = 1'b0;
		@(posedge mclk) #1;
		check("pair readback", readData, model[slot]);
		accSel = {bank, 1'b1};
		tLoad = !bank;
		aLoad = bank;
		tVal = 2'h2;
		aVal = 2'h2;
		@(posedge mclk) #1;
		accEn = 1'b0;
		tLoad = 1'b0;
		aLoad = 1'b0;
		check("pair high read", readData, model[{bank, ptr, 1'b1}]);
		check("load wins", {6'h00, (bank ? aPtr : tPtr)}, 8'h02);
	endtask : pair
	initial begin
		void'($urandom(5892));
		repeat (5) @(posedge mclk);
		#1 reset_n = 1'b1;
		check("reset pointer", {6'h00, tPtr}, 8'h00);
		check("reset alarm pointer", {6'h00, aPtr}, 8'h00);
		check("reset readValid", {7'h00, readValid}, 8'h00);
		check("reset readData", readData, 8'h00);
		unlock = 1'b1;
		for (int pass = 0; pass < 2; pass++) begin
			for (int s = 0; s < 16; s++) access(4'(s), 1'b1, pass == 0 ? 8'hff : 8'($urandom));
			for (int s = 0; s < 16; s++) access(4'(s), 1'b0, 8'h00);
		end
		$display("test unlocked writes done");
		unlock = 1'b0;
		for (int s = 0; s < 16; s++) access(4'(s), 1'b1, 8'($urandom));
		for (int s = 0; s < 16; s++) access(4'(s), 1'b0, 8'h00);
		$display("test locked writes done");
		burst(1'b0);
		burst(1'b1);
		$display("test burst done");
		for (int k = 0; k < 8; k++) begin
			unlock = 1'(k);
			pair(1'(k >> 1), 2'($urandom), 8'($urandom));
		end
		$display("test back to back done");
		// mixed random traffic; locked writes still move the pointer
		for (int k = 0; k < 200; k++) begin
			unlock = 1'($urandom);
			access(4'($urandom), 1'($urandom), 8'($urandom));
		end
		$display("test random done");
		complete_run();
	end
	// about 950 cycles expected; a large margin before calling it hung
	initial begin
		#100000;
		n_fail++;
		complete_run();
	end
endmodule : rtc_bcd_time_alarm_regs_tb_top

// ### hw/rtc_bcd_time_alarm_regs.sv
// value and alarm digit registers behind two byte windows per bank
// assumes software sets pointers and the unlock bit through outside config registers
//
// Overview of operation
// - unimplemented and reserved bits read zero
// - year holds two BCD digits, tens high
// - year write lands only when unlocked
// - month: tens bit 4, ones bits 3-0
// - day: tens bits 5-4, ones 3-0
// - weekday: three-bit digit in bits 2-0
// - hour: tens bits 5-4, ones 3-0
// - minute: tens bits 6-4, ones 3-0
// - second: tens bits 6-4, ones 3-0
// - date, hour, alarm writes need unlock
// - alarm month laid out like month
// - alarm day laid out like day
// - alarm weekday three bits, upper zero
// - time pointer decrements on high access, stops zero
// - time pointer maps fields to both windows
// - alarm pointer maps fields, decrements likewise
// - locked writes silently ignored
`timescale 1ns/1ps
module rtc_bcd_time_alarm_regs (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic value_write_unlock,
	input wire logic timePtrLoad,
	input wire logic [1:0] timePtrValue,
	input wire logic alarmPtrLoad,
	input wire logic [1:0] alarmPtrValue,
	input wire logic accEn,
	input wire logic accWrite,
	input wire logic [1:0] accSel,
	input wire logic [7:0] accWdata,
	output logic [7:0] readData,
	output logic readValid,
	output logic [1:0] time_window_pointer,
	output logic [1:0] alarm_window_pointer
);
	logic [7:0] slotData [rtc_regs_pkg::SLOT_N];
	logic [3:0] accSlot;
	logic isHigh;
	logic isAlarm;
	logic [1:0] curPtr;
	logic wrOk;
	logic [1:0] next_timePtr;
	logic [1:0] next_alarmPtr;
	logic [7:0] next_readData;
	logic next_readValid;

	always_comb begin
		isHigh = (accSel == rtc_regs_pkg::WIN_TIME_HIGH) || (accSel == rtc_regs_pkg::WIN_ALARM_HIGH);
		isAlarm = (accSel == rtc_regs_pkg::WIN_ALARM_LOW) || (accSel == rtc_regs_pkg::WIN_ALARM_HIGH);
		curPtr = isAlarm ? alarm_window_pointer : time_window_pointer;
		accSlot = {isAlarm, curPtr, isHigh};
		// every bank write goes through the unlock gate
		wrOk = accEn && accWrite && value_write_unlock;
	end

	// pointer steps on read or write of a high window, even a locked write
	always_comb begin
		next_timePtr = time_window_pointer;
		next_alarmPtr = alarm_window_pointer;
		if (timePtrLoad) begin
			next_timePtr = timePtrValue;
		end else if (accEn && accSel == rtc_regs_pkg::WIN_TIME_HIGH
				&& time_window_pointer != rtc_regs_pkg::PTR_FLOOR) begin
			next_timePtr = time_window_pointer - rtc_regs_pkg::PTR_STEP;
		end
		if (alarmPtrLoad) begin
			next_alarmPtr = alarmPtrValue;
		end else if (accEn && accSel == rtc_regs_pkg::WIN_ALARM_HIGH
				&& alarm_window_pointer != rtc_regs_pkg::PTR_FLOOR) begin
			next_alarmPtr = alarm_window_pointer - rtc_regs_pkg::PTR_STEP;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			time_window_pointer <= rtc_regs_pkg::PTR_FLOOR;
			alarm_window_pointer <= rtc_regs_pkg::PTR_FLOOR;
		end else begin
			time_window_pointer <= next_timePtr;
			alarm_window_pointer <= next_alarmPtr;
		end
	end

	// digit storage; no reset so fields power up unknown, as on the real part
	genvar gi;
	generate
		for (gi = 0; gi < rtc_regs_pkg::SLOT_N; gi++) begin : g_slot
			logic [7:0] next_slot;
			always_comb begin
				next_slot = slotData[gi];
				if (wrOk && accSlot == 4'(gi)) begin
					// digits kept as written, no BCD range check
					next_slot = accWdata & rtc_regs_pkg::SLOT_MASK[gi];
				end
			end
			always_ff @(posedge mclk) begin
				slotData[gi] <= next_slot;
			end
		end
	endgenerate

	// read answer one cycle after the strobe
	always_comb begin
		next_readValid = accEn && !accWrite;
		next_readData = rtc_regs_pkg::READ_IDLE;
		if (accEn && !accWrite) begin
			next_readData = slotData[accSlot] & rtc_regs_pkg::SLOT_MASK[accSlot];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			readData <= rtc_regs_pkg::READ_IDLE;
			readValid <= 1'b0;
		end else begin
			readData <= next_readData;
			readValid <= next_readValid;
		end
	end

	// helper state for checks only
	logic [3:0] lastSlot;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lastSlot <= rtc_regs_pkg::SLOT_SECOND;
		end else begin
			lastSlot <= accSlot;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence unlockedLowWrite;
		accEn && accWrite && value_write_unlock && !accSel[0] && !timePtrLoad && !alarmPtrLoad;
	endsequence
	sequence sameSlotRead;
		accEn && !accWrite && accSel == $past(accSel) && !timePtrLoad && !alarmPtrLoad;
	endsequence

	AST_WRITE_READBACK: assert property (
		unlockedLowWrite ##1 sameSlotRead |=> readValid
			&& readData == ($past(accWdata, 2) & rtc_regs_pkg::SLOT_MASK[lastSlot]))
		else $error("low window readback mismatch");
	AST_UNUSED_ZERO: assert property (
		readValid |-> (readData & ~rtc_regs_pkg::SLOT_MASK[lastSlot]) == rtc_regs_pkg::READ_IDLE)
		else $error("unimplemented bits read nonzero");
	AST_RESERVED_ZERO: assert property (
		accEn && !accWrite && accSel == rtc_regs_pkg::WIN_TIME_HIGH
			&& time_window_pointer == 2'h3 |=> readData == rtc_regs_pkg::READ_IDLE)
		else $error("reserved slot read nonzero");
	AST_YEAR_WRITE: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_YEAR
			|=> slotData[rtc_regs_pkg::SLOT_YEAR] == $past(accWdata))
		else $error("year did not take write");
	AST_YEAR_LOCKED: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_YEAR
			|=> $stable(slotData[rtc_regs_pkg::SLOT_YEAR]))
		else $error("year changed while locked");
	AST_LOCKED_IGNORED: assert property (
		accEn && accWrite && !value_write_unlock |=> slotData[lastSlot] == $past(slotData[accSlot]))
		else $error("locked write changed a field");
	AST_MONTH_LAYOUT: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_MONTH
			|=> slotData[rtc_regs_pkg::SLOT_MONTH] == {3'h0, $past(accWdata[4:0])})
		else $error("month layout wrong");
	AST_ALARM_WEEKDAY: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_ALARM_WEEKDAY
			|=> slotData[rtc_regs_pkg::SLOT_ALARM_WEEKDAY] == {5'h00, $past(accWdata[2:0])})
		else $error("alarm weekday layout wrong");
	AST_TIME_PTR_DEC: assert property (
		accEn && accSel == rtc_regs_pkg::WIN_TIME_HIGH && !timePtrLoad
			|=> time_window_pointer == (($past(time_window_pointer) == 2'h0)
				? 2'h0 : $past(time_window_pointer) - 2'h1))
		else $error("time pointer step wrong");
	AST_ALARM_PTR_DEC: assert property (
		accEn && accSel == rtc_regs_pkg::WIN_ALARM_HIGH && !alarmPtrLoad
			|=> alarm_window_pointer == (($past(alarm_window_pointer) == 2'h0)
				? 2'h0 : $past(alarm_window_pointer) - 2'h1))
		else $error("alarm pointer step wrong");
	AST_LOW_NO_STEP: assert property (
		accEn && !accSel[0] && !timePtrLoad && !alarmPtrLoad
			|=> $stable(time_window_pointer) && $stable(alarm_window_pointer))
		else $error("low window moved a pointer");

	// pointer loads and holds; a load outranks the step of a high access
	AST_TIME_PTR_LOAD: assert property (
		timePtrLoad |=> time_window_pointer == $past(timePtrValue))
		else $error("time pointer load lost");
	AST_ALARM_PTR_LOAD: assert property (
		alarmPtrLoad |=> alarm_window_pointer == $past(alarmPtrValue))
		else $error("alarm pointer load lost");
	AST_TIME_PTR_HOLD: assert property (
		!timePtrLoad && !(accEn && accSel == rtc_regs_pkg::WIN_TIME_HIGH)
			|=> $stable(time_window_pointer))
		else $error("time pointer moved without cause");
	AST_ALARM_PTR_HOLD: assert property (
		!alarmPtrLoad && !(accEn && accSel == rtc_regs_pkg::WIN_ALARM_HIGH)
			|=> $stable(alarm_window_pointer))
		else $error("alarm pointer moved without cause");

	// read answer stands one cycle, idle otherwise so stale data never shows
	AST_READ_VALID: assert property (
		accEn && !accWrite |=> readValid)
		else $error("read strobe gave no answer");
	AST_WRITE_NO_ANSWER: assert property (
		accEn && accWrite |=> !readValid && readData == rtc_regs_pkg::READ_IDLE)
		else $error("write strobe gave a read answer");
	AST_IDLE_QUIET: assert property (
		!accEn |=> !readValid && readData == rtc_regs_pkg::READ_IDLE)
		else $error("read port busy while idle");
	AST_YEAR_READ: assert property (
		accEn && !accWrite && accSlot == rtc_regs_pkg::SLOT_YEAR
			|=> readData == $past(slotData[rtc_regs_pkg::SLOT_YEAR]))
		else $error("year read does not match store");
	AST_ALARM_TOP_ZERO: assert property (
		accEn && !accWrite && isAlarm && alarm_window_pointer == 2'h3
			|=> readData == rtc_regs_pkg::READ_IDLE)
		else $error("alarm pointer three read nonzero");

	// each stored field keeps only its implemented digit bits
	AST_DAY_LAYOUT: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_DAY
			|=> slotData[rtc_regs_pkg::SLOT_DAY] == {2'h0, $past(accWdata[5:0])})
		else $error("day layout wrong");
	AST_WEEKDAY_LAYOUT: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_WEEKDAY
			|=> slotData[rtc_regs_pkg::SLOT_WEEKDAY] == {5'h00, $past(accWdata[2:0])})
		else $error("weekday layout wrong");
	AST_HOUR_LAYOUT: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_HOUR
			|=> slotData[rtc_regs_pkg::SLOT_HOUR] == {2'h0, $past(accWdata[5:0])})
		else $error("hour layout wrong");
	AST_MINUTE_LAYOUT: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_MINUTE
			|=> slotData[rtc_regs_pkg::SLOT_MINUTE] == {1'b0, $past(accWdata[6:0])})
		else $error("minute layout wrong");
	AST_SECOND_LAYOUT: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_SECOND
			|=> slotData[rtc_regs_pkg::SLOT_SECOND] == {1'b0, $past(accWdata[6:0])})
		else $error("second layout wrong");
	AST_ALARM_MONTH_LAYOUT: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_ALARM_MONTH
			|=> slotData[rtc_regs_pkg::SLOT_ALARM_MONTH] == {3'h0, $past(accWdata[4:0])})
		else $error("alarm month layout wrong");
	AST_ALARM_DAY_LAYOUT: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_ALARM_DAY
			|=> slotData[rtc_regs_pkg::SLOT_ALARM_DAY] == {2'h0, $past(accWdata[5:0])})
		else $error("alarm day layout wrong");
	AST_RESERVED_STORE_ZERO: assert property (
		wrOk && accSlot == rtc_regs_pkg::SLOT_RESERVED
			|=> slotData[rtc_regs_pkg::SLOT_RESERVED] == rtc_regs_pkg::READ_IDLE)
		else $error("reserved slot stored written bits");

	// locked writes leave every gated field alone
	AST_LOCKED_MONTH: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_MONTH
			|=> $stable(slotData[rtc_regs_pkg::SLOT_MONTH]))
		else $error("month changed while locked");
	AST_LOCKED_DAY: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_DAY
			|=> $stable(slotData[rtc_regs_pkg::SLOT_DAY]))
		else $error("day changed while locked");
	AST_LOCKED_WEEKDAY: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_WEEKDAY
			|=> $stable(slotData[rtc_regs_pkg::SLOT_WEEKDAY]))
		else $error("weekday changed while locked");
	AST_LOCKED_HOUR: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_HOUR
			|=> $stable(slotData[rtc_regs_pkg::SLOT_HOUR]))
		else $error("hour changed while locked");
	AST_LOCKED_ALARM_MONTH: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_ALARM_MONTH
			|=> $stable(slotData[rtc_regs_pkg::SLOT_ALARM_MONTH]))
		else $error("alarm month changed while locked");
	AST_LOCKED_ALARM_DAY: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_ALARM_DAY
			|=> $stable(slotData[rtc_regs_pkg::SLOT_ALARM_DAY]))
		else $error("alarm day changed while locked");
	AST_LOCKED_ALARM_WEEKDAY: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_ALARM_WEEKDAY
			|=> $stable(slotData[rtc_regs_pkg::SLOT_ALARM_WEEKDAY]))
		else $error("alarm weekday changed while locked");
	AST_LOCKED_SECOND: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_SECOND
			|=> $stable(slotData[rtc_regs_pkg::SLOT_SECOND]))
		else $error("second changed while locked");
	AST_LOCKED_MINUTE: assert property (
		accEn && accWrite && !value_write_unlock && accSlot == rtc_regs_pkg::SLOT_MINUTE
			|=> $stable(slotData[rtc_regs_pkg::SLOT_MINUTE]))
		else $error("minute changed while locked");

	// no chime here, so a pointer at zero never wraps to three
	AST_TIME_PTR_FLOOR: assert property (
		time_window_pointer == rtc_regs_pkg::PTR_FLOOR && !timePtrLoad
			|=> time_window_pointer == rtc_regs_pkg::PTR_FLOOR)
		else $error("time pointer wrapped below zero");
	AST_ALARM_PTR_FLOOR: assert property (
		alarm_window_pointer == rtc_regs_pkg::PTR_FLOOR && !alarmPtrLoad
			|=> alarm_window_pointer == rtc_regs_pkg::PTR_FLOOR)
		else $error("alarm pointer wrapped below zero");
	sequence timeHighAccess;
		accEn && accSel == rtc_regs_pkg::WIN_TIME_HIGH && !timePtrLoad;
	endsequence
	AST_TIME_PTR_TWO_STEPS: assert property (
		timeHighAccess ##1 timeHighAccess
			|=> time_window_pointer <= $past(time_window_pointer, 2))
		else $error("time pointer rose during high accesses");
endmodule : rtc_bcd_time_alarm_regs

// ### hw/rtc_regs_pkg.sv
// constants for the clock/calendar value and alarm register file
// assumes the config registers holding both pointers live outside this block
package rtc_regs_pkg;
	localparam int DATA_W = 8;
	localparam int PTR_W = 2;
	localparam int SLOT_W = 4;
	localparam int SLOT_N = 16;
	// window select codes on the access port
	localparam logic [1:0] WIN_TIME_LOW = 2'h0;
	localparam logic [1:0] WIN_TIME_HIGH = 2'h1;
	localparam logic [1:0] WIN_ALARM_LOW = 2'h2;
	localparam logic [1:0] WIN_ALARM_HIGH = 2'h3;
	localparam logic [1:0] PTR_FLOOR = 2'h0;
	localparam logic [1:0] PTR_STEP = 2'h1;
	// slot index is {alarm, pointer, high}
	localparam logic [3:0] SLOT_SECOND = 4'h0;
	localparam logic [3:0] SLOT_MINUTE = 4'h1;
	localparam logic [3:0] SLOT_HOUR = 4'h2;
	localparam logic [3:0] SLOT_WEEKDAY = 4'h3;
	localparam logic [3:0] SLOT_DAY = 4'h4;
	localparam logic [3:0] SLOT_MONTH = 4'h5;
	localparam logic [3:0] SLOT_YEAR = 4'h6;
	localparam logic [3:0] SLOT_RESERVED = 4'h7;
	localparam logic [3:0] SLOT_ALARM_MONTH = 4'hd;
	localparam logic [3:0] SLOT_ALARM_DAY = 4'hc;
	localparam logic [3:0] SLOT_ALARM_WEEKDAY = 4'hb;
	// implemented bits per slot; zero bits are unimplemented and read zero
	localparam logic [7:0] MASK_SECOND = 8'h7f;
	localparam logic [7:0] MASK_MINUTE = 8'h7f;
	localparam logic [7:0] MASK_HOUR = 8'h3f;
	localparam logic [7:0] MASK_WEEKDAY = 8'h07;
	localparam logic [7:0] MASK_DAY = 8'h3f;
	localparam logic [7:0] MASK_MONTH = 8'h1f;
	localparam logic [7:0] MASK_YEAR = 8'hff;
	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] SLOT_MASK [SLOT_N] = '{
		MASK_SECOND, MASK_MINUTE, MASK_HOUR, MASK_WEEKDAY,
		MASK_DAY, MASK_MONTH, MASK_YEAR, MASK_NONE,
		MASK_SECOND, MASK_MINUTE, MASK_HOUR, MASK_WEEKDAY,
		MASK_DAY, MASK_MONTH, MASK_NONE, MASK_NONE
	};
	localparam logic [7:0] READ_IDLE = 8'h00;
endpackage : rtc_regs_pkg
